//--- design/gpio_pkg.sv
/*
  Constants for the multi-port pin block: register indices, field
  positions, reset values. Assumes APB byte address = 4 * index.
*/
`default_nettype none
package gpio_pkg;
  // Register indices
  localparam logic [7:0] IDX_PULL_CTRL   = 8'h0C;
  localparam logic [7:0] IDX_DRIVE_CTRL  = 8'h0D;
  localparam logic [7:0] IDX_DATA_G      = 8'h30;
  localparam logic [7:0] IDX_DATA_H      = 8'h31;
  localparam logic [7:0] IDX_DIR_G       = 8'h32;
  localparam logic [7:0] IDX_DIR_H       = 8'h33;
  localparam logic [7:0] IDX_WAKE_EN_G   = 8'h34;
  localparam logic [7:0] IDX_WAKE_EN_H   = 8'h35;
  localparam logic [7:0] IDX_WAKE_FLG_G  = 8'h36;
  localparam logic [7:0] IDX_WAKE_FLG_H  = 8'h37;
  localparam logic [7:0] IDX_DATA_AD0    = 8'h38;
  localparam logic [7:0] IDX_DATA_AD1    = 8'h39;
  localparam logic [7:0] IDX_PWM_CTRL    = 8'h54;
  localparam logic [7:0] IDX_DATA_P      = 8'h56;
  localparam logic [7:0] IDX_DIR_P       = 8'h57;
  localparam logic [7:0] IDX_TMR_MASK2   = 8'h8D;
  localparam logic [7:0] IDX_DATA_T      = 8'hAE;
  localparam logic [7:0] IDX_DIR_T       = 8'hAF;
  localparam logic [7:0] IDX_DATA_S      = 8'hD6;
  localparam logic [7:0] IDX_DIR_S       = 8'hD7;
  localparam logic [7:0] IDX_SER_PULL_DRV = 8'hD9;
  // Field positions
  localparam int BIT_PULL_EN_H   = 7;
  localparam int BIT_PULL_EN_G   = 6;
  localparam int BIT_LOW_DRV_H   = 6;
  localparam int BIT_LOW_DRV_G   = 5;
  localparam int BIT_PWM_PULL    = 1;
  localparam int BIT_PWM_LOW_DRV = 0;
  localparam int BIT_TMR_PULL    = 5;
  localparam int BIT_TMR_LOW_DRV = 4;
  localparam int BIT_SER_PULL0   = 0;
  localparam int BIT_SER_DRV0    = 4;
  // Reset values and write masks
  localparam logic [7:0] RST_PULL_CTRL = 8'hC0;
  localparam logic [7:0] RST_ZERO      = 8'h00;
  localparam logic [7:0] MASK_PULL_CTRL  = 8'hC0;
  localparam logic [7:0] MASK_DRIVE_CTRL = 8'h60;
  localparam logic [7:0] MASK_PWM_CTRL   = 8'h03;
  localparam logic [7:0] MASK_TMR_MASK2  = 8'h30;
  localparam logic [7:0] MASK_SER_PD     = 8'h77;
  // Synchroniser input width: five 8-bit ports, two analog ports, 3 singles
  localparam int SYNC_W = 59;
endpackage
`default_nettype wire

//--- design/multi_port_gpio.sv
/*
  Pin logic for wakeup ports G/H, CAN pins, analog ports, PWM port P,
  serial port S and timer port T, with an APB register slave.
  Assumes peripherals on the same clock; pins asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module multi_port_gpio #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst_n,
  // APB slave
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [ADDR_W-1:0] i_paddr,
  input  wire logic [31:0]       i_pwdata,
  input  wire logic [3:0]        i_pstrb,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  // Mode and peripheral controls
  input  wire logic              i_periph_mode,
  input  wire logic              i_adc0_power_up,
  input  wire logic              i_adc1_power_up,
  input  wire logic [3:0]        i_pwm_channel_enable,
  input  wire logic [3:0]        i_pwm_out,
  input  wire logic [1:0]        i_async_wired_or,
  input  wire logic              i_spi_wired_or,
  input  wire logic [7:0]        i_serial_own,
  input  wire logic [7:0]        i_serial_out,
  input  wire logic [7:0]        i_serial_oe,
  input  wire logic              i_timer_enable_bit,
  input  wire logic              i_accumulator_enable,
  input  wire logic [7:0]        i_timer_own,
  input  wire logic [7:0]        i_timer_out,
  input  wire logic [7:0]        i_timer_oe,
  input  wire logic              i_can_tx_level,
  // Pin inputs
  input  wire logic [7:0]        i_pin_g,
  input  wire logic [7:0]        i_pin_h,
  input  wire logic [7:0]        i_pin_p,
  input  wire logic [7:0]        i_pin_s,
  input  wire logic [7:0]        i_pin_t,
  input  wire logic [7:0]        i_pin_ad0,
  input  wire logic [7:0]        i_pin_ad1,
  input  wire logic              i_can_receive_pin,
  input  wire logic              i_pull_select_first,
  input  wire logic              i_pull_select_second,
  // Pin outputs: G, H
  output logic [7:0]             o_out_g,
  output logic [7:0]             o_oe_g,
  output logic [7:0]             o_pull_en_g,
  output logic                   o_pull_up_g,
  output logic                   o_low_drive_g,
  output logic [7:0]             o_out_h,
  output logic [7:0]             o_oe_h,
  output logic [7:0]             o_pull_en_h,
  output logic                   o_pull_up_h,
  output logic                   o_low_drive_h,
  // Pin outputs: P, S, T
  output logic [7:0]             o_out_p,
  output logic [7:0]             o_oe_p,
  output logic [7:0]             o_pull_en_p,
  output logic                   o_low_drive_p,
  output logic [7:0]             o_out_s,
  output logic [7:0]             o_oe_s,
  output logic [7:0]             o_pull_en_s,
  output logic [7:0]             o_low_drive_s,
  output logic [7:0]             o_out_t,
  output logic [7:0]             o_oe_t,
  output logic [7:0]             o_pull_en_t,
  output logic                   o_low_drive_t,
  // CAN, analog, wakeup
  output logic                   o_can_transmit_pin,
  output logic                   o_can_rx,
  output logic                   o_ad0_digital_en,
  output logic                   o_ad1_digital_en,
  output logic                   o_wake_irq_first,
  output logic                   o_wake_irq_second
);

  // Synchronisers
  logic [gpio_pkg::SYNC_W-1:0] sync1_ff;
  logic [gpio_pkg::SYNC_W-1:0] sync2_ff;
  logic [7:0] pg, ph, pp, ps, pt, pad0, pad1;
  logic       can_rx_s, sel_g_s, sel_h_s;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= {i_pin_g, i_pin_h, i_pin_p, i_pin_s, i_pin_t, i_pin_ad0,
                   i_pin_ad1, i_can_receive_pin, i_pull_select_first,
                   i_pull_select_second};
      sync2_ff <= sync1_ff;
    end
  end

  assign {pg, ph, pp, ps, pt, pad0, pad1, can_rx_s, sel_g_s, sel_h_s} = sync2_ff;

  // APB decode
  logic [7:0] idx;
  logic       addr_ok;
  logic       setup;
  logic       wr;
  logic [7:0] wd;
  logic       hit;
  logic [7:0] rd;

  assign idx     = i_paddr[9:2];
  assign addr_ok = (i_paddr[1:0] == 2'h0) && (i_paddr[ADDR_W-1:10] == '0);
  assign setup   = i_psel && !i_penable;
  // Lane 0 only: narrow registers ignore the upper strobes
  assign wr      = i_psel && i_penable && i_pwrite && o_pready && !o_pslverr
                   && i_pstrb[0];
  assign wd      = i_pwdata[7:0];

  // Registers
  logic [7:0] data_g_ff, data_h_ff, data_p_ff, data_s_ff, data_t_ff;
  logic [7:0] dir_g_ff, dir_h_ff, dir_p_ff, dir_s_ff, dir_t_ff;
  logic [7:0] wake_en_g_ff, wake_en_h_ff;
  logic [7:0] wake_flg_g_ff, wake_flg_h_ff;
  logic [7:0] pull_ctrl_ff, drive_ctrl_ff, pwm_ctrl_ff;
  logic [7:0] tmr_mask2_ff, ser_pd_ff;
  logic       drive_written_ff;
  logic [7:0] prev_g_ff, prev_h_ff;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      data_g_ff <= gpio_pkg::RST_ZERO;
      data_h_ff <= gpio_pkg::RST_ZERO;
      data_p_ff <= gpio_pkg::RST_ZERO;
      data_s_ff <= gpio_pkg::RST_ZERO;
      data_t_ff <= gpio_pkg::RST_ZERO;
    end else if (wr) begin
      case (idx)
        gpio_pkg::IDX_DATA_G: data_g_ff <= wd;
        gpio_pkg::IDX_DATA_H: data_h_ff <= wd;
        gpio_pkg::IDX_DATA_P: data_p_ff <= wd;
        gpio_pkg::IDX_DATA_S: data_s_ff <= wd;
        gpio_pkg::IDX_DATA_T: data_t_ff <= wd;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dir_g_ff <= gpio_pkg::RST_ZERO;
      dir_h_ff <= gpio_pkg::RST_ZERO;
      dir_p_ff <= gpio_pkg::RST_ZERO;
      dir_s_ff <= gpio_pkg::RST_ZERO;
      dir_t_ff <= gpio_pkg::RST_ZERO;
    end else if (wr) begin
      case (idx)
        gpio_pkg::IDX_DIR_G: dir_g_ff <= wd;
        gpio_pkg::IDX_DIR_H: dir_h_ff <= wd;
        gpio_pkg::IDX_DIR_P: dir_p_ff <= wd;
        gpio_pkg::IDX_DIR_S: dir_s_ff <= wd;
        gpio_pkg::IDX_DIR_T: dir_t_ff <= wd;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pull_ctrl_ff <= gpio_pkg::RST_PULL_CTRL;
      pwm_ctrl_ff  <= gpio_pkg::RST_ZERO;
      tmr_mask2_ff <= gpio_pkg::RST_ZERO;
      ser_pd_ff    <= gpio_pkg::RST_ZERO;
      wake_en_g_ff <= gpio_pkg::RST_ZERO;
      wake_en_h_ff <= gpio_pkg::RST_ZERO;
    end else if (wr) begin
      case (idx)
        gpio_pkg::IDX_PULL_CTRL:    pull_ctrl_ff <= wd & gpio_pkg::MASK_PULL_CTRL;
        gpio_pkg::IDX_PWM_CTRL:     pwm_ctrl_ff  <= wd & gpio_pkg::MASK_PWM_CTRL;
        gpio_pkg::IDX_TMR_MASK2:    tmr_mask2_ff <= wd & gpio_pkg::MASK_TMR_MASK2;
        gpio_pkg::IDX_SER_PULL_DRV: ser_pd_ff    <= wd & gpio_pkg::MASK_SER_PD;
        gpio_pkg::IDX_WAKE_EN_G:    wake_en_g_ff <= wd;
        gpio_pkg::IDX_WAKE_EN_H:    wake_en_h_ff <= wd;
        default: ;
      endcase
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_ctrl_ff    <= gpio_pkg::RST_ZERO;
      drive_written_ff <= 1'h0;
    end else if (wr && idx == gpio_pkg::IDX_DRIVE_CTRL && !drive_written_ff) begin
      drive_ctrl_ff    <= wd & gpio_pkg::MASK_DRIVE_CTRL;
      drive_written_ff <= 1'h1;
    end
  end

  // falling edge flags
  // Pin level is seen whatever the direction; a new edge beats a clear
  logic [7:0] fall_g, fall_h, clr_g, clr_h;
  assign fall_g = prev_g_ff & ~pg;
  assign fall_h = prev_h_ff & ~ph;
  assign clr_g  = (wr && idx == gpio_pkg::IDX_WAKE_FLG_G) ? wd : 8'h00;
  assign clr_h  = (wr && idx == gpio_pkg::IDX_WAKE_FLG_H) ? wd : 8'h00;

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_g_ff     <= gpio_pkg::RST_ZERO;
      prev_h_ff     <= gpio_pkg::RST_ZERO;
      wake_flg_g_ff <= gpio_pkg::RST_ZERO;
      wake_flg_h_ff <= gpio_pkg::RST_ZERO;
    end else begin
      prev_g_ff     <= pg;
      prev_h_ff     <= ph;
      wake_flg_g_ff <= (wake_flg_g_ff & ~clr_g) | fall_g;
      wake_flg_h_ff <= (wake_flg_h_ff & ~clr_h) | fall_h;
    end
  end

  // Read mux
  logic drv_mapped;
  assign drv_mapped = !i_periph_mode;

  always_comb begin
    hit = 1'h1;
    rd  = 8'h00;
    case (idx)
      gpio_pkg::IDX_DATA_G:       rd = (dir_g_ff & data_g_ff) | (~dir_g_ff & pg);
      gpio_pkg::IDX_DATA_H:       rd = (dir_h_ff & data_h_ff) | (~dir_h_ff & ph);
      gpio_pkg::IDX_DATA_P:       rd = (dir_p_ff & data_p_ff) | (~dir_p_ff & pp);
      gpio_pkg::IDX_DATA_S:       rd = (dir_s_ff & data_s_ff) | (~dir_s_ff & ps);
      gpio_pkg::IDX_DATA_T:       rd = (dir_t_ff & data_t_ff) | (~dir_t_ff & pt);
      gpio_pkg::IDX_DATA_AD0:     rd = i_adc0_power_up ? 8'h00 : pad0;
      gpio_pkg::IDX_DATA_AD1:     rd = i_adc1_power_up ? 8'h00 : pad1;
      gpio_pkg::IDX_DIR_G:        rd = dir_g_ff;
      gpio_pkg::IDX_DIR_H:        rd = dir_h_ff;
      gpio_pkg::IDX_DIR_P:        rd = dir_p_ff;
      gpio_pkg::IDX_DIR_S:        rd = dir_s_ff;
      gpio_pkg::IDX_DIR_T:        rd = dir_t_ff;
      gpio_pkg::IDX_WAKE_EN_G:    rd = wake_en_g_ff;
      gpio_pkg::IDX_WAKE_EN_H:    rd = wake_en_h_ff;
      gpio_pkg::IDX_WAKE_FLG_G:   rd = wake_flg_g_ff;
      gpio_pkg::IDX_WAKE_FLG_H:   rd = wake_flg_h_ff;
      gpio_pkg::IDX_PULL_CTRL:    rd = pull_ctrl_ff;
      gpio_pkg::IDX_PWM_CTRL:     rd = pwm_ctrl_ff;
      gpio_pkg::IDX_TMR_MASK2:    rd = tmr_mask2_ff;
      gpio_pkg::IDX_SER_PULL_DRV: rd = ser_pd_ff;
      gpio_pkg::IDX_DRIVE_CTRL: begin
        hit = drv_mapped;
        rd  = drv_mapped ? drive_ctrl_ff : 8'h00;
      end
      default:                    hit = 1'h0;
    endcase
    if (!addr_ok) begin
      hit = 1'h0;
      rd  = 8'h00;
    end
  end

  // APB answer: no wait state; pready and read data come from flops loaded in the setup cycle
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pready  <= 1'h0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'h0;
    end else begin
      o_pready  <= setup;
      o_pslverr <= setup && !hit;
      if (setup) begin
        o_prdata <= (hit && !i_pwrite) ? {24'h00_0000, rd} : 32'h0000_0000;
      end
    end
  end

  // Pin drive
  logic [7:0] p_own, t_own, s_own, s_wor, nxt_oe_s, nxt_out_s;
  logic       t_on;

  assign p_own = {4'h0, i_pwm_channel_enable};
  // timer or accumulator takes its pins
  assign t_on  = i_timer_enable_bit || i_accumulator_enable;
  assign t_own = t_on ? i_timer_own : 8'h00;
  assign s_own = i_serial_own;
  assign s_wor = {{4{i_spi_wired_or}}, {2{i_async_wired_or[1]}},
                  {2{i_async_wired_or[0]}}};
  // Wired-OR only drives low; a released high gets no pull, as o_pull_en_s is off where s_own or dir_s_ff is set
  assign nxt_out_s = (s_own & i_serial_out) | (~s_own & data_s_ff);
  assign nxt_oe_s  = ((s_own & i_serial_oe) | (~s_own & dir_s_ff))
                     & ~(s_wor & nxt_out_s);

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_wake_irq_first  <= 1'h0;
      o_wake_irq_second <= 1'h0;
    end else begin
      o_wake_irq_first  <= |(wake_flg_g_ff & wake_en_g_ff);
      o_wake_irq_second <= |(wake_flg_h_ff & wake_en_h_ff);
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_g       <= 8'h00;
      o_oe_g        <= 8'h00;
      o_pull_en_g   <= 8'h00;
      o_pull_up_g   <= 1'h0;
      o_low_drive_g <= 1'h0;
      o_out_h       <= 8'h00;
      o_oe_h        <= 8'h00;
      o_pull_en_h   <= 8'h00;
      o_pull_up_h   <= 1'h0;
      o_low_drive_h <= 1'h0;
    end else begin
      o_out_g       <= data_g_ff;
      o_oe_g        <= dir_g_ff;
      o_pull_en_g   <= {8{pull_ctrl_ff[gpio_pkg::BIT_PULL_EN_G]}} & ~dir_g_ff;
      o_pull_up_g   <= sel_g_s;
      o_low_drive_g <= drive_ctrl_ff[gpio_pkg::BIT_LOW_DRV_G];
      o_out_h       <= data_h_ff;
      o_oe_h        <= dir_h_ff;
      o_pull_en_h   <= {8{pull_ctrl_ff[gpio_pkg::BIT_PULL_EN_H]}} & ~dir_h_ff;
      o_pull_up_h   <= sel_h_s;
      o_low_drive_h <= drive_ctrl_ff[gpio_pkg::BIT_LOW_DRV_H];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_p       <= 8'h00;
      o_oe_p        <= 8'h00;
      o_pull_en_p   <= 8'h00;
      o_low_drive_p <= 1'h0;
    end else begin
      o_out_p       <= (p_own & {4'h0, i_pwm_out}) | (~p_own & data_p_ff);
      o_oe_p        <= p_own | dir_p_ff;
      o_pull_en_p   <= {8{pwm_ctrl_ff[gpio_pkg::BIT_PWM_PULL]}}
                       & ~(p_own | dir_p_ff);
      o_low_drive_p <= pwm_ctrl_ff[gpio_pkg::BIT_PWM_LOW_DRV];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_s       <= 8'h00;
      o_oe_s        <= 8'h00;
      o_pull_en_s   <= 8'h00;
      o_low_drive_s <= 8'h00;
    end else begin
      o_out_s       <= nxt_out_s;
      o_oe_s        <= nxt_oe_s;
      o_pull_en_s   <= {{4{ser_pd_ff[gpio_pkg::BIT_SER_PULL0+2]}},
                        {2{ser_pd_ff[gpio_pkg::BIT_SER_PULL0+1]}},
                        {2{ser_pd_ff[gpio_pkg::BIT_SER_PULL0]}}}
                       & ~s_own & ~dir_s_ff;
      o_low_drive_s <= {{4{ser_pd_ff[gpio_pkg::BIT_SER_DRV0+2]}},
                        {2{ser_pd_ff[gpio_pkg::BIT_SER_DRV0+1]}},
                        {2{ser_pd_ff[gpio_pkg::BIT_SER_DRV0]}}};
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_t       <= 8'h00;
      o_oe_t        <= 8'h00;
      o_pull_en_t   <= 8'h00;
      o_low_drive_t <= 1'h0;
    end else begin
      o_out_t       <= (t_own & i_timer_out) | (~t_own & data_t_ff);
      o_oe_t        <= (t_own & i_timer_oe) | (~t_own & dir_t_ff);
      o_pull_en_t   <= {8{tmr_mask2_ff[gpio_pkg::BIT_TMR_PULL]}}
                       & ~((t_own & i_timer_oe) | (~t_own & dir_t_ff));
      o_low_drive_t <= tmr_mask2_ff[gpio_pkg::BIT_TMR_LOW_DRV];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_can_transmit_pin <= 1'h1;
      o_can_rx           <= 1'h1;
      o_ad0_digital_en   <= 1'h1;
      o_ad1_digital_en   <= 1'h1;
    end else begin
      o_can_transmit_pin <= i_can_tx_level;
      o_can_rx           <= can_rx_s;
      o_ad0_digital_en   <= !i_adc0_power_up;
      o_ad1_digital_en   <= !i_adc1_power_up;
    end
  end

endmodule
`default_nettype wire

//--- tb/gpio_pins_model.sv
/*
  Board-side model of the port G and H pins.
  Assumes the bench sets the external drive and its enable per pin.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
  // Block side
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pull_en,
  input  wire logic       i_pull_up,
  // Board side
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output logic [7:0]      o_level
);
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      if (i_oe[b])
        o_level[b] = i_out[b];
      else if (i_ext_en[b])
        o_level[b] = i_ext[b];
      else if (i_pull_en[b])
        o_level[b] = i_pull_up;
      else
        o_level[b] = ~i_ext[b];
    end
  end
endmodule
`default_nettype wire

//--- tb/multi_port_gpio_asserts.sv
/*
  Port checker for the multi-port pin block, bound into it.
  Assumes one clock and at most three edges of pin latency.
*/
`timescale 1ns/1ps
`default_nettype none
module gpio_asserts (
  input wire logic       i_core_clk, i_rst_n, i_psel, i_penable, o_pready, i_can_tx_level,
  input wire logic       o_can_transmit_pin, i_can_receive_pin, o_can_rx, i_pull_select_first,
  input wire logic       i_pull_select_second, o_pull_up_g, o_pull_up_h, i_spi_wired_or,
  input wire logic       i_adc0_power_up, i_adc1_power_up, o_ad0_digital_en, o_ad1_digital_en,
  input wire logic       i_timer_enable_bit,
  input wire logic [3:0] i_pwm_channel_enable, i_pwm_out,
  input wire logic [7:0] o_out_p, o_out_s, o_oe_s, o_pull_en_s, i_timer_own, i_timer_out, o_out_t
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  property p_apb_wait;
    i_psel && !i_penable |=> o_pready ##1 !o_pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("pready timing");
  property p_can_tx;
    $stable(i_can_tx_level)[*3] |-> o_can_transmit_pin == i_can_tx_level;
  endproperty
  a_can_tx: assert property (p_can_tx) else $error("can tx level");
  property p_can_rx;
    $stable(i_can_receive_pin)[*4] |-> o_can_rx == i_can_receive_pin;
  endproperty
  a_can_rx: assert property (p_can_rx) else $error("can rx level");
  property p_pull_sel;
    ($stable(i_pull_select_first) && $stable(i_pull_select_second))[*5]
      |-> o_pull_up_g == i_pull_select_first && o_pull_up_h == i_pull_select_second;
  endproperty
  a_pull_sel: assert property (p_pull_sel) else $error("pull kind");
  property p_pwm_own;
    ($stable(i_pwm_out) && $stable(i_pwm_channel_enable))[*3]
      |-> ((o_out_p[3:0] ^ i_pwm_out) & i_pwm_channel_enable) == 4'h0;
  endproperty
  a_pwm_own: assert property (p_pwm_own) else $error("pwm pin level");
  property p_spi_wor;
    i_spi_wired_or[*3] |-> (o_oe_s[7:4] & o_out_s[7:4]) == 4'h0;
  endproperty
  a_spi_wor: assert property (p_spi_wor) else $error("spi high drive");
  property p_ser_pull;
    (o_pull_en_s & o_oe_s) == 8'h00;
  endproperty
  a_ser_pull: assert property (p_ser_pull) else $error("pull on output");
  property p_adc_dig;
    ($stable(i_adc0_power_up) && $stable(i_adc1_power_up))[*3]
      |-> o_ad0_digital_en != i_adc0_power_up && o_ad1_digital_en != i_adc1_power_up;
  endproperty
  a_adc_dig: assert property (p_adc_dig) else $error("analog input mode");
  property p_tmr_own;
    (i_timer_enable_bit && $stable(i_timer_own) && $stable(i_timer_out))[*3]
      |-> ((o_out_t ^ i_timer_out) & i_timer_own) == 8'h00;
  endproperty
  a_tmr_own: assert property (p_tmr_own) else $error("timer pin level");
endmodule
bind multi_port_gpio gpio_asserts u_gpio_asserts (.*);
`default_nettype wire

//--- tb/tb_top.sv
/*
  Bench: registers over APB, wakeup, drive and peripheral pin takeover.
  Assumes the pin model on ports G and H and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        i_core_clk, i_rst_n, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [3:0]  i_pstrb, i_pwm_channel_enable, i_pwm_out;
  logic [1:0]  i_async_wired_or;
  logic        i_periph_mode, i_adc0_power_up, i_adc1_power_up, i_spi_wired_or;
  logic        i_timer_enable_bit, i_accumulator_enable, i_can_tx_level, i_can_receive_pin;
  logic        i_pull_select_first, i_pull_select_second, o_pull_up_g, o_pull_up_h;
  logic        o_low_drive_g, o_low_drive_h, o_low_drive_p, o_low_drive_t, o_can_transmit_pin;
  logic        o_can_rx, o_ad0_digital_en, o_ad1_digital_en, o_wake_irq_first, o_wake_irq_second;
  logic [7:0]  i_serial_own, i_serial_out, i_serial_oe, i_timer_own, i_timer_out, i_timer_oe;
  logic [7:0]  i_pin_g, i_pin_h, i_pin_p, i_pin_s, i_pin_t, i_pin_ad0, i_pin_ad1, ext_en;
  logic [7:0]  o_out_g, o_oe_g, o_pull_en_g, o_out_h, o_oe_h, o_pull_en_h, o_out_p, o_oe_p;
  logic [7:0]  o_pull_en_p, o_out_s, o_oe_s, o_pull_en_s, o_low_drive_s, o_out_t, o_oe_t;
  logic [7:0]  o_pull_en_t;
  logic [15:0] ext;
  int          n_fail, comparisons;
  multi_port_gpio DUT (.*);
  gpio_pins_model u_pins_g (.i_out(o_out_g), .i_oe(o_oe_g), .i_pull_en(o_pull_en_g),
    .i_pull_up(o_pull_up_g), .i_ext(ext[7:0]), .i_ext_en(ext_en), .o_level(i_pin_g));
  gpio_pins_model u_pins_h (.i_out(o_out_h), .i_oe(o_oe_h), .i_pull_en(o_pull_en_h),
    .i_pull_up(o_pull_up_h), .i_ext(ext[15:8]), .i_ext_en(ext_en), .o_level(i_pin_h));
  initial begin
    i_core_clk = 1'h0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Holds the request until pready; a lost answer ends the run
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge i_core_clk);
    i_psel <= 1'h1;
    i_pwrite <= wr;
    i_paddr <= {2'h0, idx, 2'h0};
    i_pwdata <= {24'h0, wd};
    @(posedge i_core_clk);
    i_penable <= 1'h1;
    n = 0;
    do begin
      @(posedge i_core_clk);
      n++;
    end while (o_pready !== 1'h1 && n < 16);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
    if (n >= 16) begin
      n_fail++;
      close_out();
    end
  endtask
  task automatic t_reset();
    logic [7:0] ix [7] = '{gpio_pkg::IDX_DIR_G, gpio_pkg::IDX_DIR_H, gpio_pkg::IDX_DIR_P,
      gpio_pkg::IDX_DIR_T, gpio_pkg::IDX_DIR_S, gpio_pkg::IDX_PWM_CTRL, gpio_pkg::IDX_TMR_MASK2};
    foreach (ix[k]) begin
      apb(1'h0, ix[k], 8'h00);
      chk("reset_reg", 8'h00, rd);
    end
    chk("pull_g", 8'hFF, o_pull_en_g);
    chk("tx_recessive", 1'h1, o_can_transmit_pin);
  endtask
  task automatic t_wake(input logic h);
    int n;
    apb(1'h1, gpio_pkg::IDX_WAKE_EN_G + {7'h0, h}, 8'h01);
    ext <= h ? 16'hFEFC : 16'hFFFE;
    n = 0;
    do begin
      @(negedge i_core_clk);
      n++;
    end while ((h ? o_wake_irq_second : o_wake_irq_first) !== 1'h1 && n < 8);
    chk("wake_irq", 1'h1, h ? o_wake_irq_second : o_wake_irq_first);
    apb(1'h0, gpio_pkg::IDX_WAKE_FLG_G + {7'h0, h}, 8'h00);
    chk("wake_flag", 8'h01, rd);
    apb(1'h1, gpio_pkg::IDX_WAKE_FLG_G + {7'h0, h}, 8'h01);
    ext <= h ? 16'hFCFC : 16'hFFFC;
    repeat (6) @(negedge i_core_clk);
    chk("irq_masked", 1'h0, h ? o_wake_irq_second : o_wake_irq_first);
    apb(1'h0, gpio_pkg::IDX_WAKE_FLG_G + {7'h0, h}, 8'h00);
    chk("flag_masked", 8'h02, rd);
  endtask
  task automatic t_dir();
    @(posedge i_core_clk);
    i_pull_select_second <= 1'h0;
    apb(1'h1, gpio_pkg::IDX_DIR_G, 8'h5A);
    apb(1'h1, gpio_pkg::IDX_DIR_H, 8'hA5);
    apb(1'h1, gpio_pkg::IDX_DIR_P, 8'h0F);
    apb(1'h1, gpio_pkg::IDX_DIR_T, 8'hF0);
    apb(1'h1, gpio_pkg::IDX_DIR_S, 8'h3C);
    apb(1'h1, gpio_pkg::IDX_SER_PULL_DRV, 8'h14);
    repeat (2) @(negedge i_core_clk);
    chk("oe_g", 8'h5A, o_oe_g);
    chk("pull_g", 8'hA5, o_pull_en_g);
    chk("oe_h", 8'hA5, o_oe_h);
    chk("pull_h", 9'h05A, {o_pull_up_h, o_pull_en_h});
    chk("oe_p", 8'h0F, o_oe_p);
    chk("oe_t", 8'hF0, o_oe_t);
    chk("pull_s", 8'hC0, o_pull_en_s);
    chk("drive_s", 8'h03, o_low_drive_s);
  endtask
  task automatic t_drive();
    apb(1'h1, gpio_pkg::IDX_DRIVE_CTRL, 8'h60);
    apb(1'h1, gpio_pkg::IDX_DRIVE_CTRL, 8'h00);
    apb(1'h0, gpio_pkg::IDX_DRIVE_CTRL, 8'h00);
    chk("drive_ctrl", 8'h60, rd);
    chk("low_drv_gh", 2'h3, {o_low_drive_g, o_low_drive_h});
    apb(1'h1, gpio_pkg::IDX_PWM_CTRL, 8'h03);
    apb(1'h1, gpio_pkg::IDX_TMR_MASK2, 8'h30);
    apb(1'h0, gpio_pkg::IDX_PWM_CTRL, 8'h00);
    chk("pwm_ctrl", 8'h03, rd);
    chk("pwm_pins", 9'h1F0, {o_low_drive_p, o_pull_en_p});
    chk("tmr_pins", 9'h10F, {o_low_drive_t, o_pull_en_t});
    i_periph_mode <= 1'h1;
    apb(1'h0, gpio_pkg::IDX_DRIVE_CTRL, 8'h00);
    chk("drive_hidden", 1'h1, err);
    i_periph_mode <= 1'h0;
    apb(1'h0, 8'h01, 8'h00);
    chk("unmapped", 1'h1, err);
  endtask
  task automatic t_periph();
    @(posedge i_core_clk);
    {i_can_tx_level, i_can_receive_pin, i_spi_wired_or, i_timer_enable_bit} <= 4'h3;
    {i_pwm_channel_enable, i_pwm_out, i_async_wired_or} <= 10'h17F;
    {i_serial_own, i_serial_out, i_serial_oe} <= 24'hFFF5FF;
    {i_timer_own, i_timer_out, i_timer_oe} <= 24'h33FFFF;
    {i_pin_p, i_pin_s, i_pin_t, i_pin_ad0, i_pin_ad1} <= 40'hA5A5A5A53C;
    repeat (5) @(negedge i_core_clk);
    chk("can_pins", 2'h0, {o_can_transmit_pin, o_can_rx});
    chk("pwm_out", 4'h5, o_out_p[3:0]);
    chk("wired_or", 8'h0A, o_oe_s);
    chk("timer_out", 8'h33, o_out_t);
    apb(1'h0, gpio_pkg::IDX_DATA_AD1, 8'h00);
    chk("ad1_gpio", 8'h3C, rd);
    {i_timer_enable_bit, i_accumulator_enable, i_adc1_power_up, i_adc0_power_up} <= 4'h7;
    apb(1'h0, gpio_pkg::IDX_DATA_AD1, 8'h00);
    chk("ad1_analog", 8'h00, rd);
    chk("acc_out", 8'h33, o_out_t);
  endtask
  initial begin
    {i_rst_n, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_periph_mode} = '0;
    {i_adc0_power_up, i_adc1_power_up, i_pwm_channel_enable, i_pwm_out, i_async_wired_or} = '0;
    {i_spi_wired_or, i_serial_own, i_serial_out, i_serial_oe, i_accumulator_enable} = '0;
    {i_timer_enable_bit, i_timer_own, i_timer_out, i_timer_oe} = '0;
    {i_pin_p, i_pin_s, i_pin_t, i_pin_ad0, i_pin_ad1} = '0;
    {i_can_tx_level, i_can_receive_pin, i_pull_select_first, i_pull_select_second} = 4'hF;
    {i_pstrb, ext, ext_en} = 28'hFFFFFFF;
    n_fail = 0;
    comparisons = 0;
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'h1;
    t_reset();
    t_wake(1'h0);
    t_wake(1'h1);
    t_dir();
    t_drive();
    t_periph();
    close_out();
  end
endmodule
`default_nettype wire
